// *** hdl/aps_sequencer.sv ***
// arbitrary waveform playback, trigger and marker sequencer with ahb-lite registers
//
// Overview of operation
// - even start address entered is lowered by one to odd
// - odd length entered is flagged and lowered by one to even
// - free-running mode plays without pause, ignoring triggers
// - single-cycle mode plays one cycle per trigger event
// - burst mode plays N cycles per event, N from 2 to 999999
// - gated mode keeps playing cycles while the gate is held
// - non-continuous output starts at phase -360..+360 deg in 0.1 deg steps
// - zero-phase command resets the phase reference for unit alignment
// - keypress source makes one trigger per keypress
// - on-board source makes periodic triggers at the programmed rate
// - point rate sets sample stepping, held until reprogrammed
// - level is amplitude times sample over 16382 plus offset
// - samples span -8191..+8191 for full scale
// - one sample bank of 400000 points, waveforms by start and length
// - marker pulse while playback is inside a programmed address window
// - marker window at most 4000 points, marker switchable
// - start or length change restarts output on the new window at once
// - channel 2 takes the rear point clock only when both select it
// - frequency standard is selectable on-board or rear
// - no sweep and no start phase with the arbitrary function
// - sample addresses run 1 through 400000
// - one sync pulse per generated waveform cycle
`default_nettype none
module aps_sequencer
  import aps_pkg::*;
(
  input  wire  logic               i_mclk,
  input  wire  logic               i_sys_rst,
  input  wire  logic               i_hsel,
  input  wire  logic [31:0]        i_haddr,
  input  wire  logic [1:0]         i_htrans,
  input  wire  logic               i_hwrite,
  input  wire  logic [2:0]         i_hsize,
  input  wire  logic [31:0]        i_hwdata,
  input  wire  logic               i_hready,
  output var   logic               o_hreadyout,
  output var   logic               o_hresp,
  output var   logic [31:0]        o_hrdata,
  input  wire  logic               i_trig,
  input  wire  logic               i_rear_pt_tick,
  input  wire  logic signed [13:0] i_mem_data,
  output var   logic [AW-1:0]      o_mem_addr,
  output var   logic signed [17:0] o_level,
  output var   logic               o_sync,
  output var   logic               o_marker,
  output var   logic               o_ch2_rear_clk,
  output var   logic               o_rear_freq_std,
  output var   logic               o_sweep_active
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] sat(input logic [31:0] d, input logic [31:0] lo, input logic [31:0] hi);
    sat = (d < lo) ? lo : ((d > hi) ? hi : d);
  endfunction

  function automatic logic [AW-1:0] fix_start(input logic [31:0] d);
    logic [31:0] v;
    v = sat(d, ADDR_MIN, ADDR_MAX - 32'h1);
    fix_start = AW'(v[0] ? v : v - 32'h1);
  endfunction

  function automatic logic [AW-1:0] fix_len(input logic [31:0] d, input logic [AW-1:0] st);
    logic [31:0] v;
    v = sat(d, LEN_MIN, ADDR_MAX - {13'h0, st} + 32'h1);
    fix_len = AW'({v[31:1], 1'b0});
  endfunction

  function automatic logic signed [17:0] scale(input logic signed [13:0] smp, input logic [15:0] amp,
                                               input logic signed [15:0] ofs);
    logic signed [13:0] s;
    logic signed [31:0] p;
    s = (smp > $signed(SAMPLE_MAX)) ? $signed(SAMPLE_MAX)
      : ((smp < -$signed(SAMPLE_MAX)) ? -$signed(SAMPLE_MAX) : smp);
    p = $signed({16'h0000, amp}) * $signed({{18{s[13]}}, s});
    p = p / $signed(SAMPLE_SPAN);
    scale = 18'(p + $signed({{16{ofs[15]}}, ofs}));
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  aps_ctrl_s          ctrl;
  logic [AW-1:0]      start;
  logic [AW-1:0]      len;
  logic [19:0]        cycles;
  logic [23:0]        pt_div;
  logic [23:0]        trig_div;
  logic signed [12:0] phase;
  logic [15:0]        ampl;
  logic signed [15:0] offs;
  logic [AW-1:0]      mark_addr;
  logic [11:0]        mark_len;
  logic               odd_flag;
  logic               wr_pend;
  logic [7:0]         wr_ofs;
  logic               win_chg;
  logic               zero_cmd;
  logic               key_ev;

  typedef enum logic {ST_IDLE, ST_RUN} aps_state_e;
  aps_state_e    state;
  logic [AW-1:0] pos;
  logic [AW-1:0] pt_in_cyc;
  logic [19:0]   cyc;

  wire logic addr_ph = i_hsel & i_htrans[1] & i_hready;
  wire logic wr_en   = wr_pend;
  wire logic odd_set = wr_en & (wr_ofs == OFS_LENGTH) & i_hwdata[0];

  // ---------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend     <= 1'b0;
      wr_ofs      <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend     <= addr_ph & i_hwrite & (i_haddr[31:8] == 24'h000000);
      wr_ofs      <= i_haddr[7:0];
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // read data is fetched at the address phase so it stands in the data phase
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0;
    end else if (addr_ph & ~i_hwrite) begin
      unique case (i_haddr)
        {24'h0, OFS_CTRL}:      o_hrdata <= {21'h0, ctrl};
        {24'h0, OFS_START}:     o_hrdata <= {13'h0, start};
        {24'h0, OFS_LENGTH}:    o_hrdata <= {13'h0, len};
        {24'h0, OFS_CYCLES}:    o_hrdata <= {12'h0, cycles};
        {24'h0, OFS_PT_DIV}:    o_hrdata <= {8'h0, pt_div};
        {24'h0, OFS_TRIG_DIV}:  o_hrdata <= {8'h0, trig_div};
        {24'h0, OFS_PHASE}:     o_hrdata <= {{19{phase[12]}}, phase};
        {24'h0, OFS_AMPL}:      o_hrdata <= {16'h0, ampl};
        {24'h0, OFS_OFFSET}:    o_hrdata <= {{16{offs[15]}}, offs};
        {24'h0, OFS_MARK_ADDR}: o_hrdata <= {13'h0, mark_addr};
        {24'h0, OFS_MARK_LEN}:  o_hrdata <= {20'h0, mark_len};
        {24'h0, OFS_STATUS}:    o_hrdata <= {30'h0, odd_flag, state == ST_RUN};
        {24'h0, OFS_POSITION}:  o_hrdata <= {13'h0, pos};
        default:                o_hrdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl      <= RST_CTRL;
      start     <= RST_START;
      len       <= RST_LENGTH;
      cycles    <= RST_CYCLES;
      pt_div    <= RST_PT_DIV;
      trig_div  <= RST_TRIG_DIV;
      phase     <= 13'sh0;
      ampl      <= RST_AMPL;
      offs      <= 16'sh0;
      mark_addr <= RST_START;
      mark_len  <= RST_MARK_LEN;
    end else if (wr_en) begin
      unique case (wr_ofs)
        OFS_CTRL:      ctrl      <= aps_ctrl_s'(i_hwdata[10:0]);
        OFS_START:     start     <= fix_start(i_hwdata);
        OFS_LENGTH:    len       <= fix_len(i_hwdata, start);
        OFS_CYCLES:    cycles    <= 20'(sat(i_hwdata, CYC_MIN, CYC_MAX));
        OFS_PT_DIV:    pt_div    <= i_hwdata[23:0];
        OFS_TRIG_DIV:  trig_div  <= i_hwdata[23:0];
        OFS_PHASE:     phase     <= ($signed(i_hwdata) > $signed(PH_FULL)) ? 13'(PH_FULL)
                                  : (($signed(i_hwdata) < -$signed(PH_FULL)) ? -13'(PH_FULL)
                                  : i_hwdata[12:0]);
        OFS_AMPL:      ampl      <= i_hwdata[15:0];
        OFS_OFFSET:    offs      <= i_hwdata[15:0];
        OFS_MARK_ADDR: mark_addr <= AW'(sat(i_hwdata, ADDR_MIN, ADDR_MAX));
        OFS_MARK_LEN:  mark_len  <= 12'(sat(i_hwdata, 32'h1, MARK_MAX));
        default: ;
      endcase
    end
  end

  // hardware set wins over the software clear
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      odd_flag <= 1'b0;
    end else if (odd_set) begin
      odd_flag <= 1'b1;
    end else if (wr_en & (wr_ofs == OFS_CMD) & i_hwdata[CMD_CLR_ODD]) begin
      odd_flag <= 1'b0;
    end
  end

  // one-cycle events out of register writes
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_chg  <= 1'b0;
      zero_cmd <= 1'b0;
      key_ev   <= 1'b0;
    end else begin
      win_chg  <= wr_en & ((wr_ofs == OFS_START) | (wr_ofs == OFS_LENGTH));
      zero_cmd <= wr_en & (wr_ofs == OFS_CMD) & i_hwdata[CMD_ZERO];
      key_ev   <= wr_en & (wr_ofs == OFS_CMD) & i_hwdata[CMD_KEYPRESS];
    end
  end

  // ---------------------------------------------------------------
  // point clock and trigger sources
  // ---------------------------------------------------------------
  logic [23:0] pt_cnt;
  logic [23:0] int_cnt;
  logic        int_sq;
  logic        trig_q;
  wire logic   int_tick = (int_cnt == 24'h0);
  wire logic   pt_tick  = ctrl.rear_point_clock ? i_rear_pt_tick : (pt_cnt == 24'h0);

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pt_cnt <= RST_PT_DIV;
    end else if (zero_cmd | (pt_cnt == 24'h0)) begin
      pt_cnt <= pt_div;
    end else begin
      pt_cnt <= pt_cnt - 24'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      int_cnt <= RST_TRIG_DIV;
      int_sq  <= 1'b0;
      trig_q  <= 1'b0;
    end else begin
      // a new rate takes hold at once, not after the old count has run out
      if (wr_en & (wr_ofs == OFS_TRIG_DIV)) begin
        int_cnt <= i_hwdata[23:0];
      end else begin
        int_cnt <= int_tick ? trig_div : int_cnt - 24'h1;
      end
      int_sq  <= int_tick ? ~int_sq : int_sq;
      trig_q  <= i_trig;
    end
  end

  logic trig_ev;
  logic gate_lvl;
  always_comb begin
    unique case (ctrl.src)
      APS_KEYPRESS_SOURCE:   begin trig_ev = key_ev;             gate_lvl = ctrl.man_gate; end
      APS_ON_BOARD_RATE:     begin trig_ev = int_tick;           gate_lvl = int_sq;        end
      APS_REAR_INPUT_SOURCE: begin trig_ev = i_trig & ~trig_q;   gate_lvl = i_trig;        end
      default:               begin trig_ev = 1'b0;               gate_lvl = 1'b0;          end
    endcase
  end

  // ---------------------------------------------------------------
  // start phase in points, none with the arbitrary function
  // ---------------------------------------------------------------
  logic [11:0] ph_mag;
  logic [31:0] ph_off;
  logic [AW-1:0] pos0;
  always_comb begin
    ph_mag = 12'(phase[12] ? -phase : phase);
    ph_off = (({13'h0, len} * {20'h0, ph_mag}) / PH_FULL) % {13'h0, len};
    if (ctrl.arb_func | (ctrl.mode == APS_FREE_RUNNING_OUTPUT) | (ph_off == 32'h0)) begin
      pos0 = '0;
    end else if (phase[12]) begin
      pos0 = len - AW'(ph_off);
    end else begin
      pos0 = AW'(ph_off);
    end
  end

  // ---------------------------------------------------------------
  // playback sequencer
  // ---------------------------------------------------------------
  wire logic last   = (pt_in_cyc == len - AW'(1));
  wire logic wrap   = (state == ST_RUN) & pt_tick & last;
  logic      stop;
  logic      go;
  always_comb begin
    unique case (ctrl.mode)
      APS_FREE_RUNNING_OUTPUT: begin stop = 1'b0;                        go = 1'b1;     end
      APS_SINGLE_CYCLE:        begin stop = 1'b1;                        go = trig_ev;  end
      APS_N_CYCLES_PER_EVENT:  begin stop = (cyc + 20'h1 >= cycles);     go = trig_ev;  end
      APS_GATED:               begin stop = ~gate_lvl;                   go = gate_lvl; end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state     <= ST_IDLE;
      pos       <= '0;
      pt_in_cyc <= '0;
      cyc       <= 20'h0;
      o_sync    <= 1'b0;
    end else if (win_chg | zero_cmd) begin
      pos       <= pos0;
      pt_in_cyc <= '0;
      cyc       <= 20'h0;
      o_sync    <= (state == ST_RUN);
    end else if (state == ST_IDLE) begin
      pos       <= pos0;
      pt_in_cyc <= '0;
      cyc       <= 20'h0;
      o_sync    <= go;
      if (go) begin
        state <= ST_RUN;
      end
    end else if (pt_tick) begin
      pt_in_cyc <= last ? '0 : pt_in_cyc + AW'(1);
      pos       <= last ? pos0 : ((pos == len - AW'(1)) ? '0 : pos + AW'(1));
      cyc       <= last ? cyc + 20'h1 : cyc;
      o_sync    <= last & ~stop;
      if (last & stop) begin
        state <= ST_IDLE;
      end
    end else begin
      o_sync <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sample address, level and marker
  // ---------------------------------------------------------------
  wire logic [AW-1:0] cur_addr = start + pos;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_addr      <= RST_START;
      o_level         <= 18'sh0;
      o_marker        <= 1'b0;
      o_ch2_rear_clk  <= 1'b0;
      o_rear_freq_std <= 1'b0;
      o_sweep_active  <= 1'b0;
    end else begin
      o_mem_addr      <= cur_addr;
      o_level         <= scale(i_mem_data, ampl, offs);
      o_marker        <= ctrl.marker_on & (state == ST_RUN) & (cur_addr >= mark_addr)
                       & ({1'b0, cur_addr} < {1'b0, mark_addr} + {8'h0, mark_len});
      o_ch2_rear_clk  <= ctrl.rear_point_clock & ctrl.ch2_rear_point_clock;
      o_rear_freq_std <= ctrl.rear_freq_standard;
      o_sweep_active  <= ctrl.sweep_req & ~ctrl.arb_func;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_START_ODD: assert property (start[0]) else $error("start address even");
  AST_LEN_EVEN: assert property (odd_set |=> (len[0] == 1'b0) && odd_flag) else $error("odd length kept");
  AST_FREE_RUNNING_OUTPUT_RUNS: assert property ((ctrl.mode == APS_FREE_RUNNING_OUTPUT) && (state == ST_RUN)
                                  && $stable(ctrl.mode) |=> state == ST_RUN) else $error("free run stopped");
  AST_SINGLE_STOP: assert property ((ctrl.mode == APS_SINGLE_CYCLE) && wrap && !win_chg && !zero_cmd
                                    |=> state == ST_IDLE) else $error("single cycle overran");
  AST_BURST_BOUND: assert property ((ctrl.mode == APS_N_CYCLES_PER_EVENT) && (state == ST_RUN)
                                    && $stable(cycles) |-> cyc < cycles) else $error("burst overran");
  AST_GATE_STOP: assert property ((ctrl.mode == APS_GATED) && wrap && !gate_lvl && !win_chg && !zero_cmd
                                  |=> state == ST_IDLE) else $error("gate ignored");
  AST_MARK_MAX: assert property (mark_len <= 12'(MARK_MAX) && mark_len != 12'h0) else $error("marker too long");
  AST_ADDR_RANGE: assert property ({13'h0, o_mem_addr} >= ADDR_MIN && {13'h0, o_mem_addr} <= ADDR_MAX)
    else $error("sample address out of range");
  AST_SYNC_ONE: assert property (o_sync |=> !o_sync) else $error("sync longer than one cycle");
  AST_NO_RETRIG: assert property ((state == ST_RUN) && !pt_tick && !win_chg && !zero_cmd
                                  |=> $stable(pos)) else $error("mid-run restart");
  AST_MARK_OFF: assert property (!ctrl.marker_on |=> !o_marker) else $error("marker while off");

  COV_BURST: cover property ((ctrl.mode == APS_N_CYCLES_PER_EVENT) && wrap && stop);
  COV_GATE:  cover property ((ctrl.mode == APS_GATED) && (state == ST_RUN) ##1 state == ST_IDLE);
  COV_MARK:  cover property (!o_marker ##1 o_marker);
  COV_WIN:   cover property ((state == ST_RUN) && win_chg);
endmodule // aps_sequencer
`default_nettype wire

// *** hdl/aps_pkg.sv ***
// shared constants, register map and types of the arbitrary playback sequencer
`default_nettype none
package aps_pkg;
  // ---------------------------------------------------------------
  // sample memory and field limits
  // ---------------------------------------------------------------
  localparam int unsigned AW          = 19;
  localparam logic [31:0] ADDR_MIN    = 32'h0000_0001;
  localparam logic [31:0] ADDR_MAX    = 32'h0006_1a80;   // 400000
  localparam logic [31:0] LEN_MIN     = 32'h0000_0002;
  localparam logic [31:0] CYC_MIN     = 32'h0000_0002;
  localparam logic [31:0] CYC_MAX     = 32'h000f_423f;   // 999999
  localparam logic [31:0] MARK_MAX    = 32'h0000_0fa0;   // 4000
  localparam logic [31:0] PH_FULL     = 32'h0000_0e10;   // 3600 tenths of a degree
  localparam logic [31:0] SAMPLE_SPAN = 32'h0000_3ffe;   // 16382
  localparam logic [13:0] SAMPLE_MAX  = 14'h1fff;        // 8191
  localparam logic [31:0] DIV_MAX     = 32'h00ff_ffff;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_START     = 8'h04;
  localparam logic [7:0] OFS_LENGTH    = 8'h08;
  localparam logic [7:0] OFS_CYCLES    = 8'h0c;
  localparam logic [7:0] OFS_PT_DIV    = 8'h10;
  localparam logic [7:0] OFS_TRIG_DIV  = 8'h14;
  localparam logic [7:0] OFS_PHASE     = 8'h18;
  localparam logic [7:0] OFS_AMPL      = 8'h1c;
  localparam logic [7:0] OFS_OFFSET    = 8'h20;
  localparam logic [7:0] OFS_MARK_ADDR = 8'h24;
  localparam logic [7:0] OFS_MARK_LEN  = 8'h28;
  localparam logic [7:0] OFS_CMD       = 8'h2c;
  localparam logic [7:0] OFS_STATUS    = 8'h30;
  localparam logic [7:0] OFS_POSITION  = 8'h34;

  // command bits
  localparam int unsigned CMD_KEYPRESS = 0;
  localparam int unsigned CMD_ZERO     = 1;
  localparam int unsigned CMD_CLR_ODD  = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [18:0] RST_START    = 19'h00001;
  localparam logic [18:0] RST_LENGTH   = 19'h00400;
  localparam logic [19:0] RST_CYCLES   = 20'h00002;
  localparam logic [23:0] RST_PT_DIV   = 24'h000000;
  localparam logic [23:0] RST_TRIG_DIV = 24'h0003e7;
  localparam logic [15:0] RST_AMPL     = 16'h1388;
  localparam logic [11:0] RST_MARK_LEN = 12'h001;

  typedef enum logic [1:0] {
    APS_FREE_RUNNING_OUTPUT,
    APS_SINGLE_CYCLE,
    APS_N_CYCLES_PER_EVENT,
    APS_GATED
  } aps_mode_e;

  typedef enum logic [1:0] {
    APS_KEYPRESS_SOURCE,
    APS_ON_BOARD_RATE,
    APS_REAR_INPUT_SOURCE
  } aps_src_e;

  typedef struct packed {
    logic      man_gate;               // [10]
    logic      sweep_req;              // [9]
    logic      arb_func;               // [8]
    logic      rear_freq_standard;     // [7]
    logic      ch2_rear_point_clock;   // [6]
    logic      rear_point_clock;       // [5]
    logic      marker_on;              // [4]
    aps_src_e  src;                    // [3:2]
    aps_mode_e mode;                   // [1:0]
  } aps_ctrl_s;

  localparam aps_ctrl_s RST_CTRL = '{man_gate: 1'b0, sweep_req: 1'b0, arb_func: 1'b1,
                                     rear_freq_standard: 1'b0, ch2_rear_point_clock: 1'b0,
                                     rear_point_clock: 1'b0, marker_on: 1'b0,
                                     src: APS_KEYPRESS_SOURCE, mode: APS_FREE_RUNNING_OUTPUT};
endpackage
`default_nettype wire

// *** dv/aps_src_model.sv ***
// partner model: rear trigger or gate source and rear point clock
`default_nettype none
module aps_src_model (
  input  wire logic i_clk,
  input  wire logic i_fire,
  input  wire logic i_gate,
  input  wire logic i_tick_en,
  output var  logic o_trig = 1'b0,
  output var  logic o_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       hold = 1'b0;
  logic [1:0] div  = 2'h0;
  // ---------------------------------------------------------------
  // a fired trigger stands two cycles so its rising edge is seen
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    hold   <= i_fire;
    o_trig <= i_gate | i_fire | hold;
    div    <= div + 2'h1;
    o_tick <= i_tick_en & (div == 2'h3);
  end
endmodule  // aps_src_model
`default_nettype wire

// *** dv/tb.sv ***
// bench top: register bus master, playback scenarios and verdict
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aps_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0;
  logic [31:0]        hwdata = 32'h0;
  logic signed [13:0] mem = 14'h0000;
  logic               fire = 1'b0;
  logic               gate = 1'b0;
  logic               tick_en = 1'b0;
  logic               hready, hresp, sync, marker, ch2, rfs, swp, trig, tick;
  logic [31:0]        hrdata, r;
  logic [18:0]        maddr;
  logic signed [17:0] level;
  int                 n_fail = 0, checked = 0, n_sync = 0, n_mark = 0, s0, m0;
  aps_sequencer dut (.i_mclk(clk), .i_sys_rst(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_trig(trig), .i_rear_pt_tick(tick), .i_mem_data(mem),
    .o_mem_addr(maddr), .o_level(level), .o_sync(sync), .o_marker(marker), .o_ch2_rear_clk(ch2),
    .o_rear_freq_std(rfs), .o_sweep_active(swp));
  aps_src_model src (.i_clk(clk), .i_fire(fire), .i_gate(gate), .i_tick_en(tick_en), .o_trig(trig),
    .o_tick(tick));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (sync === 1'b1) n_sync <= n_sync + 1;
    if (marker === 1'b1) n_mark <= n_mark + 1;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 100);
    r = hrdata;
    if (k >= 100) begin n_fail++; conclude(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0); chk(r, e); endtask
  task automatic wt(input int n); repeat (n) @(posedge clk); endtask
  task automatic mark0(); s0 = n_sync; m0 = n_mark; endtask
  task automatic pulse(); fire <= 1'b1; wt(1); fire <= 1'b0; endtask
  // syncs counted over n cycles since mark0; marker cycles too when m is not negative
  task automatic span(input int n, input int e, input int m);
    wt(n);
    chk(n_sync - s0, e);
    if (m >= 0) chk(n_mark - m0, m);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_win();
    rdc(OFS_CTRL, 32'h100);
    rdc(OFS_LENGTH, 32'h400);
    rdc(8'h3c, 32'h0);
    wr(OFS_START, 32'h0);
    rdc(OFS_START, 32'h1);
    wr(OFS_START, 32'h7d0);
    rdc(OFS_START, 32'h7cf);
    wr(OFS_LENGTH, 32'h3e9);
    rdc(OFS_LENGTH, 32'h3e8);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r & 32'h2, 32'h2);
    wr(OFS_CMD, 32'h4);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r & 32'h2, 32'h0);
  endtask
  task automatic t_free();
    wr(OFS_START, 32'h1);
    wr(OFS_LENGTH, 32'h4);
    wr(OFS_MARK_ADDR, 32'h2);
    wr(OFS_MARK_LEN, 32'h2);
    wr(OFS_CTRL, 32'h110);
    wt(8);
    mark0();
    span(40, 10, 20);
    wr(OFS_MARK_LEN, 32'h1388);
    rdc(OFS_MARK_LEN, 32'hfa0);
    wr(OFS_PT_DIV, 32'h1);
    wr(OFS_CTRL, 32'h100);
    wt(8);
    mark0();
    span(40, 5, 0);
    wr(OFS_PT_DIV, 32'h0);
    wr(OFS_CTRL, 32'h120);
    tick_en <= 1'b1;
    wt(20);
    mark0();
    span(160, 10, -1);
    tick_en <= 1'b0;
  endtask
  task automatic t_trig();
    wr(OFS_START, 32'h5);
    wr(OFS_CTRL, 32'h109);
    wt(10);
    chk({13'h0, maddr}, 32'h5);
    mark0();
    pulse();
    span(30, 1, -1);
    wr(OFS_CYCLES, 32'h3);
    wr(OFS_CTRL, 32'h10a);
    wt(10);
    mark0();
    pulse();
    wt(4);
    pulse();
    span(50, 3, -1);
    wr(OFS_CTRL, 32'h10b);
    gate <= 1'b1;
    wt(10);
    mark0();
    span(40, 10, -1);
    gate <= 1'b0;
    wt(10);
    mark0();
    span(20, 0, -1);
    wr(OFS_CTRL, 32'h101);
    mark0();
    wr(OFS_CMD, 32'h1);
    span(20, 1, -1);
    wr(OFS_TRIG_DIV, 32'h13);
    wr(OFS_CTRL, 32'h105);
    wt(30);
    mark0();
    span(200, 10, -1);
  endtask
  task automatic t_phase();
    wr(OFS_CTRL, 32'h001);
    wr(OFS_PHASE, 32'h384);
    wt(10);
    chk({13'h0, maddr}, 32'h6);
    wr(OFS_PHASE, 32'hfffffc7c);
    wt(10);
    chk({13'h0, maddr}, 32'h8);
    wr(OFS_CTRL, 32'h101);
    wt(4);
    chk({13'h0, maddr}, 32'h5);
    wr(OFS_PT_DIV, 32'h63);
    wr(OFS_CTRL, 32'h100);
    wt(150);
    wr(OFS_CMD, 32'h2);
    wt(1);
    rdc(OFS_POSITION, 32'h0);
  endtask
  task automatic t_misc();
    wr(OFS_AMPL, 32'h3ffe);
    wr(OFS_OFFSET, 32'h5);
    mem <= 14'sd8191;
    wt(3);
    chk({14'h0, level}, 32'h2004);
    wr(OFS_OFFSET, 32'h0);
    mem <= -14'sd8191;
    wt(3);
    chk({14'h0, level}, 32'h3e001);
    wr(OFS_CTRL, 32'h2e0);
    wt(2);
    chk({29'h0, ch2, rfs, swp}, 32'h7);
    wr(OFS_CTRL, 32'h320);
    wt(2);
    chk({29'h0, ch2, rfs, swp}, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    t_win();
    t_free();
    t_trig();
    t_phase();
    t_misc();
    conclude();
  end
endmodule  // tb
`default_nettype wire
